// [tb/microstep_table_sequencer_bench.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the microstep table sequencer
module microstep_table_sequencer_bench
  import mts_pkg::*;
;
  logic                  core_clk;
  logic                  rstn      = 1'b0;
  logic                  clkEn     = 1'b1;
  logic                  stepIn    = 1'b0;
  logic                  dirOn     = 1'b1;
  logic                  modeOn    = 1'b1;
  logic [2:0]            blk       = 3'h0;
  logic [2:0]            lvl       = 3'h0;
  logic                  manualA0  = 1'b0;
  logic                  hostWrN   = 1'b0;
  logic                  hostWrNOe = 1'b0;
  logic                  hostA1    = 1'b0;
  logic                  hostA1Oe  = 1'b0;
  logic [REG_AW-1:0]     regAddr   = 4'h0;
  logic [DATA_W-1:0]     regWrData = 16'h0000;
  logic                  regWr     = 1'b0;
  logic                  regRd     = 1'b0;
  logic [DATA_W-1:0]     regRdData;
  logic [7:0]            tableData;
  logic [TBL_ADDR_W-1:0] tableAddr;
  logic [AMP_W-1:0]      w1Amp;
  logic [AMP_W-1:0]      w2Amp;
  logic                  w1Dir;
  logic                  w2Dir;
  mts_phase_t            w1Ph;
  mts_phase_t            w2Ph;
  logic [15:0]           nPow;
  logic [15:0]           nFast;
  logic [7:0]            cnt;
  int                    mismatches  = 0;
  int                    totalChecks = 0;
  int                    cycles      = 0;

  // ========================================================
  // Design and table memory
  mts_sequencer dut (
    .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .stepIn(stepIn), .dirOn(dirOn), .modeOn(modeOn),
    .block_select_bit0(blk[0]), .block_select_bit1(blk[1]),
    .block_select_bit2(blk[2]), .decay_level_bit0(lvl[0]),
    .decay_level_bit1(lvl[1]), .decay_level_bit2(lvl[2]),
    .manualA0(manualA0), .hostWrN(hostWrN), .hostWrNOe(hostWrNOe),
    .hostA1(hostA1), .hostA1Oe(hostA1Oe), .tableData(tableData),
    .tableAddr(tableAddr), .winding1Amp(w1Amp),
    .winding1_direction(w1Dir), .winding2Amp(w2Amp),
    .winding2_direction(w2Dir), .winding1Phase(w1Ph),
    .winding2Phase(w2Ph), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData)
  );
  mts_table_mem tbl (
    .core_clk(core_clk), .tableAddr(tableAddr), .tableData(tableData)
  );

  // ========================================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  // ========================================================
  // Shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  // One-cycle read strobe; data stands in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] m,
                    input logic [15:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData & m, exp);
  endtask
  // Filtered pin pulse: step rise or write strobe fall
  task automatic toggle(input bit wrLine);
    if (wrLine)
      hostWrN <= 1'b0;
    else
      stepIn <= 1'b1;
    repeat (8) @(posedge core_clk);
    if (wrLine)
      hostWrN <= 1'b1;
    else
      stepIn <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // Step, then check address and the winding fed by that byte
  task automatic stepChk(input logic [7:0] c);
    toggle(1'b0);
    chk(16'(tableAddr), {1'b0, 4'hC, blk, c});
    chk(c[0] ? 16'({w2Dir, w2Amp}) : 16'({w1Dir, w1Amp}),
        16'({c[0] ^ blk[0], ~c[7:1]}));
  endtask
  // Count winding one phases over one whole PWM period
  task automatic window(input logic [15:0] expPow,
                        input logic [15:0] expFast);
    nPow = 16'h0000;
    nFast = 16'h0000;
    repeat (PWM_PERIOD_CYC) @(posedge core_clk);
    repeat (PWM_PERIOD_CYC) begin
      @(posedge core_clk);
      #1;
      if (w1Ph === PH_POWER)
        nPow++;
      if (w1Ph === PH_FAST)
        nFast++;
    end
    chk(nPow, expPow);
    chk(nFast, expFast);
  endtask

  // ========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(16'({w1Ph, w2Ph}), 16'h0000);
    rd(REG_CTRL, 16'hFFFF, 16'h0000);
    rd(REG_ONTIME, 16'hFFFF, 16'h03E8);
    rd(REG_THRESH, 16'hFFFF, 16'h0000);
    rd(4'hF, 16'hFFFF, 16'h0000);
    // Block field is valid once the pin filter has filled
    chk(16'(tableAddr), 16'h6000);
    rd(REG_STATUS, 16'hC000, 16'hC000);
    // Host takes the strobe and address lines from the pull-ups
    hostWrNOe <= 1'b1;
    hostA1Oe <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(REG_STATUS, 16'hC000, 16'h0000);
    hostWrN <= 1'b1;
    modeOn <= 1'b0;
    lvl <= 3'h7;
    repeat (8) @(posedge core_clk);
    // Manual mode: load winding one, then winding two
    toggle(1'b1);
    manualA0 <= 1'b1;
    lvl <= 3'h3;
    repeat (8) @(posedge core_clk);
    toggle(1'b1);
    rd(REG_STATUS, 16'h3F00, 16'h1F00);
    chk(16'(tableAddr[0]), 16'h0001);
    // Windings hold the even byte of block 0, step 0; odd never read
    chk(16'({w1Dir, w1Amp, w2Dir, w2Amp}), 16'h7F00);
    // Stepping mode in block five, counting up
    modeOn <= 1'b1;
    manualA0 <= 1'b0;
    blk <= 3'h5;
    repeat (8) @(posedge core_clk);
    for (int i = 1; i <= 4; i++) stepChk(8'(i));
    // Phase lengths with falling amplitude and level seven
    wr(REG_ONTIME, 16'h0064);
    window(16'h0064, 16'h076C);
    wr(REG_THRESH, 16'h012C);
    wr(REG_CTRL, 16'h0001);
    window(16'h0064, 16'h012C);
    wr(REG_THRESH, 16'h0000);
    window(16'h0064, 16'h0000);
    // Count down through zero
    dirOn <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = 3; i >= -1; i--) stepChk(8'(i));
    // Coarser resolutions, then an out-of-range code
    dirOn <= 1'b1;
    cnt = 8'hFF;
    for (int r = 1; r <= 6; r++) begin
      wr(REG_CTRL, 16'((r << 1) | 1));
      cnt = cnt + 8'(1 << (r > 5 ? 5 : r));
      repeat (8) @(posedge core_clk);
      stepChk(cnt);
    end
    // Frozen core ignores a whole step pulse
    clkEn <= 1'b0;
    toggle(1'b0);
    clkEn <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk(16'(tableAddr), {1'b0, 4'hC, blk, cnt});
    rd(REG_CTRL, 16'hFFFF, 16'h000B);
    finish_test();
  end
endmodule

// [tb/mts_table_mem.sv]
`timescale 1ns/1ps
// ==========================================================
// Table memory model on the far side of the sequencer
module mts_table_mem
  import mts_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic [TBL_ADDR_W-1:0] tableAddr,
  output logic [7:0]                 tableData
);
  // ========================================================
  // Every byte of every block holds a value; one-cycle read.
  // Amplitude falls as the counter rises; sign mixes parity
  // and block bit 0 so both fields are seen to move.
  always_ff @(posedge core_clk) begin
    tableData <= {tableAddr[0] ^ tableAddr[8], ~tableAddr[7:1]};
  end
endmodule

// [verilog/mts_phase_gen.sv]
`timescale 1ns/1ps
// ==========================================================
// PWM phase generator for one winding
module mts_phase_gen
  import mts_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             clkEn,
  input  wire logic [CNT_W-1:0] pwmCnt,
  input  wire logic [CNT_W-1:0] onTime,
  input  wire logic [CNT_W-1:0] threshold,
  input  wire logic             advanced,
  input  wire logic [LVL_W-1:0] level,
  input  wire logic             decreasing,
  output mts_phase_t            phase
);

  typedef struct packed {
    mts_phase_t ph;
  } mts_pg_state_t;

  mts_pg_state_t st;
  mts_pg_state_t nx;
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] fastLen;
  logic [CNT_W-1:0] cap;
  logic             fastOk;

  // ========================================================
  // Phase selection
  always_comb begin
    nx      = st;
    remain  = PWM_LAST - pwmCnt;
    fastLen = CNT_W'(level * LVL_STEP);
    fastOk  = (level != '0) && decreasing;
    // In advanced decay the fast window is capped by the threshold
    cap = (fastLen < threshold) ? fastLen : threshold;
    if (!rstn) begin
      nx.ph = PH_POWER;
    end else if (pwmCnt < onTime) begin
      nx.ph = PH_POWER;
    end else if (!fastOk) begin
      nx.ph = PH_SLOW;
    end else if (!advanced) begin
      nx.ph = PH_FAST;
    end else if (remain < cap) begin
      nx.ph = PH_FAST;
    end else begin
      nx.ph = PH_SLOW;
    end
  end

  // State register, frozen while clkEn is low
  always_ff @(posedge core_clk) begin
    if (!rstn || clkEn) begin
      st <= nx;
    end
  end

  assign phase = st.ph;

endmodule

// [verilog/mts_pkg.sv]
// ==========================================================
// Shared constants for the microstep table sequencer
package mts_pkg;

  // ========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PWM_PERIOD_NS  = 20000;
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LVL_STEP_CYC   = PWM_PERIOD_CYC / 8;
  localparam int CNT_W          = 11;
  localparam logic [CNT_W-1:0] PWM_LAST =
    CNT_W'(PWM_PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] LVL_STEP = CNT_W'(LVL_STEP_CYC);

  // ========================================================
  // Table layout
  localparam int STEP_W     = 8;
  localparam int BLK_W      = 3;
  localparam int AMP_W      = 7;
  localparam int LVL_W      = 3;
  localparam int DIR_BIT    = 7;
  localparam int TBL_ADDR_W = 15;
  localparam int TBL_BLK_LSB = 8;
  // Upper address bits 14..11: two ones, then two zeros
  localparam logic [3:0] TBL_HI_FIXED = 4'hC;

  // ========================================================
  // Resolution codes: 0 = 1/32 ... 5 = full step
  localparam logic [2:0] RES_MAX = 3'h5;

  // ========================================================
  // Register map
  localparam int REG_AW = 4;
  localparam int DATA_W = 16;
  localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [REG_AW-1:0] REG_ONTIME = 4'h1;
  localparam logic [REG_AW-1:0] REG_THRESH = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
  localparam logic [REG_AW-1:0] REG_WIND   = 4'h4;
  localparam int CTRL_ADV_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam logic [CNT_W-1:0] ONTIME_RST = 11'h3E8;
  localparam logic [CNT_W-1:0] THRESH_RST = 11'h000;

  // ========================================================
  // Synchronised pin vector positions
  localparam int PIN_STEP = 0;
  localparam int PIN_DIR  = 1;
  localparam int PIN_MODE = 2;
  localparam int PIN_BLK  = 3;
  localparam int PIN_LVL  = 6;
  localparam int PIN_MA0  = 9;
  localparam int PIN_WRN  = 10;
  localparam int PIN_A1   = 11;
  localparam int PIN_W    = 12;

  typedef enum logic [1:0] {
    PH_POWER,
    PH_SLOW,
    PH_FAST
  } mts_phase_t;

endpackage

// [verilog/mts_sequencer.sv]
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
// ==========================================================
// Microstep table sequencer: step counter, table addressing,
// winding data capture, decay levels and PWM phases

// Contract
// - Normal decay: power, then slow or fast.
// - Advanced decay: power, slow, fast in order.
// - Fast phase capped; zero threshold disables. Code does both in advanced decay only.
// - Resolutions 1/32 default down to full.
// - Each winding gets amplitude and direction.
// - Even bytes winding one, odd winding two.
// - Bits 0-6 amplitude, bit 7 direction.
// - Block is 256 addresses; counter low bits.
// - Three select bits pick one of eight.
// - Address bits 11,12 zero; 13,14 one.
// - Undriven write strobe and A1 read high.
// - Step rise counts up or down by direction.
// - Manual mode feeds level bits and A0.
// - Fast decay only while amplitude falls.
// - Per-winding 3-bit level, 7 max, 0 none.
module mts_sequencer
  import mts_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  clkEn,
  input  wire logic                  stepIn,
  input  wire logic                  dirOn,
  input  wire logic                  modeOn,
  input  wire logic                  block_select_bit0,
  input  wire logic                  block_select_bit1,
  input  wire logic                  block_select_bit2,
  input  wire logic                  decay_level_bit0,
  input  wire logic                  decay_level_bit1,
  input  wire logic                  decay_level_bit2,
  input  wire logic                  manualA0,
  input  wire logic                  hostWrN,
  input  wire logic                  hostWrNOe,
  input  wire logic                  hostA1,
  input  wire logic                  hostA1Oe,
  input  wire logic [7:0]            tableData,
  output logic [TBL_ADDR_W-1:0]      tableAddr,
  output logic [AMP_W-1:0]           winding1Amp,
  output logic                       winding1_direction,
  output logic [AMP_W-1:0]           winding2Amp,
  output logic                       winding2_direction,
  output mts_phase_t                 winding1Phase,
  output mts_phase_t                 winding2Phase,
  input  wire logic [REG_AW-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic [DATA_W-1:0]          regRdData
);

  typedef struct packed {
    logic [PIN_W-1:0]      s1;
    logic [PIN_W-1:0]      s2;
    logic [PIN_W-1:0]      s3;
    logic [PIN_W-1:0]      pinF;
    logic [STEP_W-1:0]     cnt;
    logic [CNT_W-1:0]      pwmCnt;
    logic [CNT_W-1:0]      onTime;
    logic [CNT_W-1:0]      thr;
    logic                  adv;
    logic [2:0]            res;
    logic [LVL_W-1:0]      lvl1;
    logic [LVL_W-1:0]      lvl2;
    logic [TBL_ADDR_W-1:0] tAddr;
    logic                  pendV;
    logic                  pendLsb;
    logic [AMP_W-1:0]      amp1;
    logic [AMP_W-1:0]      amp2;
    logic                  dir1;
    logic                  dir2;
    logic                  decr1;
    logic                  decr2;
    logic [DATA_W-1:0]     rd;
  } mts_state_t;

  mts_state_t       st;
  mts_state_t       nx;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] fNew;
  logic             stepRise;
  logic             wrFall;
  logic             modeNow;
  logic [STEP_W-1:0] stride;

  // ========================================================
  // Functions

  // Filter: take the new value only where stages two and
  // three agree
  function automatic logic [PIN_W-1:0] agreeFilt(
    input logic [PIN_W-1:0] a,
    input logic [PIN_W-1:0] b,
    input logic [PIN_W-1:0] held
  );
    logic [PIN_W-1:0] same;
    same = ~(a ^ b);
    return (b & same) | (held & ~same);
  endfunction

  // Amplitude trend: 1 falling, 0 rising, hold if equal
  function automatic logic trendDown(
    input logic [AMP_W-1:0] newAmp,
    input logic [AMP_W-1:0] oldAmp,
    input logic             held
  );
    if (newAmp < oldAmp) begin
      return 1'b1;
    end else if (newAmp > oldAmp) begin
      return 1'b0;
    end
    return held;
  endfunction

  // Counter stride for a resolution code
  function automatic logic [STEP_W-1:0] resStride(
    input logic [2:0] r
  );
    return STEP_W'(1) << r;
  endfunction

  // ========================================================
  // Pin gathering with pull-ups on undriven host lines
  always_comb begin
    pinRaw = '0;
    pinRaw[PIN_STEP] = stepIn;
    pinRaw[PIN_DIR]  = dirOn;
    pinRaw[PIN_MODE] = modeOn;
    pinRaw[PIN_BLK +: BLK_W] =
      {block_select_bit2, block_select_bit1, block_select_bit0};
    pinRaw[PIN_LVL +: LVL_W] =
      {decay_level_bit2, decay_level_bit1, decay_level_bit0};
    pinRaw[PIN_MA0] = manualA0;
    pinRaw[PIN_WRN] = hostWrNOe ? hostWrN : 1'b1;
    pinRaw[PIN_A1]  = hostA1Oe ? hostA1 : 1'b1;
  end

  // ========================================================
  // Next-state logic
  always_comb begin
    nx       = st;
    fNew     = agreeFilt(st.s2, st.s3, st.pinF);
    stepRise = fNew[PIN_STEP] & ~st.pinF[PIN_STEP];
    wrFall   = ~fNew[PIN_WRN] & st.pinF[PIN_WRN];
    modeNow  = fNew[PIN_MODE];
    stride   = resStride(st.res);

    // Three-stage synchroniser
    nx.s1   = pinRaw;
    nx.s2   = st.s1;
    nx.s3   = st.s2;
    nx.pinF = fNew;

    // Step counter, wraps naturally at 256
    if (stepRise) begin
      if (fNew[PIN_DIR]) begin
        nx.cnt = st.cnt + stride;
      end else begin
        nx.cnt = st.cnt - stride;
      end
    end

    // Decay level load in manual mode
    if (!modeNow && (stepRise || wrFall)) begin
      if (!fNew[PIN_MA0]) begin
        nx.lvl1 = fNew[PIN_LVL +: LVL_W];
      end else begin
        nx.lvl2 = fNew[PIN_LVL +: LVL_W];
      end
    end

    // Table address: fixed top, block, step counter
    nx.tAddr[TBL_ADDR_W-1 -: 4] = TBL_HI_FIXED;
    nx.tAddr[TBL_BLK_LSB +: BLK_W] =
      fNew[PIN_BLK +: BLK_W];
    nx.tAddr[STEP_W-1:1] = nx.cnt[STEP_W-1:1];
    nx.tAddr[0] = modeNow ? nx.cnt[0]
                          : fNew[PIN_MA0];

    // Data follows the address by one cycle
    nx.pendV   = modeNow;
    nx.pendLsb = st.tAddr[0];
    if (st.pendV && !st.pendLsb) begin
      nx.amp1  = tableData[AMP_W-1:0];
      nx.dir1  = tableData[DIR_BIT];
      nx.decr1 = trendDown(tableData[AMP_W-1:0], st.amp1,
                           st.decr1);
    end
    if (st.pendV && st.pendLsb) begin
      nx.amp2  = tableData[AMP_W-1:0];
      nx.dir2  = tableData[DIR_BIT];
      nx.decr2 = trendDown(tableData[AMP_W-1:0], st.amp2,
                           st.decr2);
    end

    // PWM period counter
    nx.pwmCnt = (st.pwmCnt == PWM_LAST) ? '0
                                        : st.pwmCnt + 1'b1;

    // Register writes
    if (regWr) begin
      unique case (regAddr)
        REG_CTRL: begin
          nx.adv = regWrData[CTRL_ADV_BIT];
          if (regWrData[CTRL_RES_LSB +: 3] <= RES_MAX) begin
            nx.res = regWrData[CTRL_RES_LSB +: 3];
          end
        end
        REG_ONTIME: nx.onTime = regWrData[CNT_W-1:0];
        REG_THRESH: nx.thr = regWrData[CNT_W-1:0];
        default: ;
      endcase
    end

    // Register reads, data valid the cycle after
    nx.rd = '0;
    if (regRd) begin
      unique case (regAddr)
        REG_CTRL: nx.rd = DATA_W'({st.res, st.adv});
        REG_ONTIME: nx.rd = DATA_W'(st.onTime);
        REG_THRESH: nx.rd = DATA_W'(st.thr);
        REG_STATUS: nx.rd = {st.pinF[PIN_A1], st.pinF[PIN_WRN],
                             st.lvl2, st.lvl1, st.cnt};
        REG_WIND: nx.rd = {st.dir2, st.amp2, st.dir1, st.amp1};
        default: nx.rd = '0;
      endcase
    end

    // Synchronous reset
    if (!rstn) begin
      nx        = '0;
      nx.s1     = '1;
      nx.s2     = '1;
      nx.s3     = '1;
      nx.pinF   = '1;
      nx.onTime = ONTIME_RST;
      nx.thr    = THRESH_RST;
      nx.tAddr[TBL_ADDR_W-1 -: 4] = TBL_HI_FIXED;
    end
  end

  // State register, frozen while clkEn is low
  always_ff @(posedge core_clk) begin
    if (!rstn || clkEn) begin
      st <= nx;
    end
  end

  // ========================================================
  // Phase generators, one per winding
  mts_phase_gen u_phase1 (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .pwmCnt     (st.pwmCnt),
    .onTime     (st.onTime),
    .threshold  (st.thr),
    .advanced   (st.adv),
    .level      (st.lvl1),
    .decreasing (st.decr1),
    .phase      (winding1Phase)
  );

  mts_phase_gen u_phase2 (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .pwmCnt     (st.pwmCnt),
    .onTime     (st.onTime),
    .threshold  (st.thr),
    .advanced   (st.adv),
    .level      (st.lvl2),
    .decreasing (st.decr2),
    .phase      (winding2Phase)
  );

  // ========================================================
  // Outputs straight from state
  assign tableAddr          = st.tAddr;
  assign winding1Amp        = st.amp1;
  assign winding1_direction = st.dir1;
  assign winding2Amp        = st.amp2;
  assign winding2_direction = st.dir2;
  assign regRdData          = st.rd;

  // ========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_step_up;
    clkEn && stepRise && fNew[PIN_DIR];
  endsequence

  sequence s_step_down;
    clkEn && stepRise && !fNew[PIN_DIR];
  endsequence

  a_table_hi_bits: assert property (
    $past(rstn) |-> tableAddr[TBL_ADDR_W-1 -: 4] == TBL_HI_FIXED)
    else $error("table address top bits wrong");

  a_block_field: assert property (
    rstn && clkEn |=> tableAddr[TBL_BLK_LSB +: BLK_W]
              == $past(fNew[PIN_BLK +: BLK_W]))
    else $error("block select not on address");

  a_step_count_up: assert property (
    s_step_up |=> st.cnt == STEP_W'($past(st.cnt) + $past(stride)))
    else $error("counter did not count up");

  a_step_count_down: assert property (
    s_step_down |=> st.cnt
                    == STEP_W'($past(st.cnt) - $past(stride)))
    else $error("counter did not count down");

  a_even_to_one: assert property (
    clkEn && st.pendV && !st.pendLsb |=>
      winding1Amp == $past(tableData[AMP_W-1:0]) &&
      winding1_direction == $past(tableData[DIR_BIT]))
    else $error("even byte not on winding one");

  a_odd_to_two: assert property (
    clkEn && st.pendV && st.pendLsb |=>
      winding2Amp == $past(tableData[AMP_W-1:0]) &&
      winding2_direction == $past(tableData[DIR_BIT]))
    else $error("odd byte not on winding two");

  a_manual_addr0: assert property (
    rstn && clkEn && !modeNow |=> tableAddr[0] == $past(fNew[PIN_MA0]))
    else $error("manual A0 not on address");

  a_fast_needs_fall: assert property (
    clkEn && winding1Phase != PH_FAST ##1
      winding1Phase == PH_FAST |-> $past(st.decr1) &&
      $past(st.lvl1) != '0)
    else $error("fast decay without falling amplitude");

  a_zero_thresh_off: assert property (
    clkEn && st.adv && st.thr == '0 |=>
      winding2Phase != PH_FAST)
    else $error("fast decay with zero threshold");

  a_power_first: assert property (
    clkEn && st.pwmCnt == '0 && st.onTime != '0 |=>
      winding1Phase == PH_POWER && winding2Phase == PH_POWER)
    else $error("period did not open with power phase");

  a_pullup_wr: assert property (
    !hostWrNOe [*4] |-> st.s3[PIN_WRN])
    else $error("undriven write strobe not high");

  a_read_unmapped: assert property (
    regRd && regAddr > REG_WIND |=> regRdData == '0)
    else $error("unmapped read not zero");

endmodule
